// *** wsc_ctx_switch.sv ***
/*
  Workspace addressing and context-switch sequencer.
  Assumes memory answers each held request with a one-cycle mem_ack_i on mclk_i.
*/
module wsc_ctx_switch (
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  trap_req_i,
  input  wire wsc_pkg::wsc_trap_t    trap_kind_i,
  input  wire logic [15:0]           trap_vec_i,
  input  wire logic                  trap_ld_st_i,
  input  wire logic [15:0]           trap_st_i,
  input  wire logic [15:0]           trap_ea_i,
  input  wire logic                  ret_req_i,
  input  wire logic                  ext_enter_i,
  input  wire logic                  ext_return_i,
  input  wire logic                  macro_trap_i,
  input  wire logic                  reg_req_i,
  input  wire logic                  reg_role_sel_i,
  input  wire wsc_pkg::wsc_role_t    reg_role_i,
  input  wire logic [3:0]            reg_num_i,
  input  wire logic                  reg_idx_i,
  input  wire logic                  macro_acc_i,
  input  wire logic [15:0]           macro_addr_i,
  input  wire logic                  mem_ack_i,
  input  wire logic [15:0]           mem_rdata_i,
  output logic                       mem_req_o,
  output logic                       mem_we_o,
  output logic [15:0]                mem_addr_o,
  output logic [15:0]                mem_wdata_o,
  output logic [3:0]                 mem_code_o,
  output logic [15:0]                reg_addr_o,
  output logic                       reg_addr_vld_o,
  output logic                       idx_fault_o,
  output logic [3:0]                 macro_code_o,
  output wsc_pkg::wsc_mregion_t      macro_region_o,
  output logic [15:0]                wp_o,
  output logic [15:0]                pc_o,
  output logic [15:0]                st_o,
  output logic                       busy_o,
  output logic                       ext_owner_o,
  output logic                       macro_mode_o
);
  import wsc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_RD_WP, S_WP_UPD, S_RD_PC, S_WR13, S_WR14, S_WR15, S_WR11,
    S_RD13, S_RD14, S_RD15, S_ST_UPD, S_EXT_WAIT
  } wsc_state_t;
  typedef enum logic [1:0] {M_TRAP, M_RET, M_EXT} wsc_mode_t;

  // ---------------------------------------------------------------
  // State and data registers
  // ---------------------------------------------------------------
  wsc_state_t   state,   next_state;
  wsc_mode_t    mode,    next_mode;
  logic [15:0]  base,    next_base;
  logic [15:0]  vec,     next_vec;
  logic [15:0]  tmp_wp,  next_tmp_wp;
  logic [15:0]  tmp_pc,  next_tmp_pc;
  logic [15:0]  tmp_st,  next_tmp_st;
  logic [15:0]  old_wp,  next_old_wp;
  logic [15:0]  old_pc,  next_old_pc;
  logic [15:0]  old_st,  next_old_st;
  logic [15:0]  ea,      next_ea;
  logic         is_xop,  next_is_xop;
  logic         ld_st,   next_ld_st;
  logic         rst_pend, next_rst_pend;
  logic [15:0]  next_wp, next_pc, next_st;
  logic         next_ext_owner, next_macro_mode;
  logic [3:0]   seq_reg;
  logic [15:0]  seq_addr;
  logic         bus_req, bus_we;
  logic [15:0]  bus_addr, bus_wdata;
  logic [3:0]   bus_code;
  logic [3:0]   op_reg;
  logic [15:0]  op_addr;
  logic         op_idx_ok;
  wsc_mregion_t m_region;

  // Sequencer address of the next bus state's register
  wsc_ws_addr u_seq_addr (
    .base_i   (next_base),
    .reg_num_i(seq_reg),
    .addr_o   (seq_addr),
    .idx_ok_o ()
  );

  // Operand address for the instruction unit
  wsc_ws_addr u_op_addr (
    .base_i   (wp_o),
    .reg_num_i(op_reg),
    .addr_o   (op_addr),
    .idx_ok_o (op_idx_ok)
  );

  // Macro space region of the current access
  wsc_macro_map u_macro_map (
    .addr_i  (macro_addr_i),
    .region_o(m_region)
  );

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;      next_mode = mode;       next_base = base;
    next_vec = vec;          next_tmp_wp = tmp_wp;   next_tmp_pc = tmp_pc;
    next_tmp_st = tmp_st;    next_old_wp = old_wp;   next_old_pc = old_pc;
    next_old_st = old_st;    next_ea = ea;           next_is_xop = is_xop;
    next_ld_st = ld_st;      next_rst_pend = rst_pend;
    next_wp = wp_o;          next_pc = pc_o;         next_st = st_o;
    next_ext_owner = ext_owner_o;
    next_macro_mode = macro_mode_o;
    unique case (state)
      S_IDLE: begin
        if (rst_pend || trap_req_i) begin
          // Fetch the new context, then save the running one into the new workspace
          next_state    = S_RD_WP;
          next_mode     = M_TRAP;
          next_rst_pend = 1'b0;
          next_vec      = rst_pend ? RESET_VEC : (trap_vec_i & WORD_MASK);
          next_is_xop   = !rst_pend && trap_kind_i == TRAP_EXT_OP;
          next_ld_st    = !rst_pend && trap_ld_st_i;
          next_tmp_st   = trap_st_i;
          next_ea       = trap_ea_i;
          next_old_wp   = wp_o;
          next_old_pc   = pc_o;
          next_old_st   = st_o;
        end else if (ret_req_i) begin
          next_state = S_RD13;
          next_mode  = M_RET;
          next_base  = wp_o;
        end else if (ext_enter_i) begin
          // Hand the context to the outside party through memory
          next_state  = S_WR13;
          next_mode   = M_EXT;
          next_base   = wp_o;
          next_old_wp = wp_o;
          next_old_pc = pc_o;
          next_old_st = st_o;
        end else if (macro_trap_i) begin
          next_pc         = MACRO_TRAP_PC;
          next_macro_mode = 1'b1;
        end
      end
      S_RD_WP: if (mem_ack_i) begin
        next_tmp_wp = mem_rdata_i & WORD_MASK;
        next_base   = mem_rdata_i & WORD_MASK;
        next_state  = S_WP_UPD;
      end
      S_WP_UPD: if (mem_ack_i) begin
        next_wp = tmp_wp;
        if (mode == M_RET) begin
          next_pc         = tmp_pc;
          next_st         = tmp_st;
          next_macro_mode = 1'b0;
          next_ext_owner  = 1'b0;
          next_state      = S_ST_UPD;
        end else begin
          next_state = S_RD_PC;
        end
      end
      S_RD_PC: if (mem_ack_i) begin
        next_pc    = mem_rdata_i & WORD_MASK;
        next_state = S_WR13;
      end
      S_WR13: if (mem_ack_i) next_state = S_WR14;
      S_WR14: if (mem_ack_i) next_state = S_WR15;
      S_WR15: if (mem_ack_i) begin
        if (mode == M_EXT) begin
          next_state     = S_EXT_WAIT;
          next_ext_owner = 1'b1;
        end else if (is_xop) begin
          next_state = S_WR11;
        end else if (ld_st) begin
          next_st    = tmp_st;
          next_state = S_ST_UPD;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_WR11: if (mem_ack_i) begin
        next_st    = ld_st ? tmp_st : st_o;
        next_state = ld_st ? S_ST_UPD : S_IDLE;
      end
      S_EXT_WAIT: if (ext_return_i) begin
        next_state = S_RD13;
        next_mode  = M_RET;
      end
      S_RD13: if (mem_ack_i) begin
        next_tmp_wp = mem_rdata_i & WORD_MASK;
        next_state  = S_RD14;
      end
      S_RD14: if (mem_ack_i) begin
        next_tmp_pc = mem_rdata_i & WORD_MASK;
        next_state  = S_RD15;
      end
      S_RD15: if (mem_ack_i) begin
        next_tmp_st = mem_rdata_i;
        next_state  = S_WP_UPD;
      end
      S_ST_UPD: if (mem_ack_i) next_state = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus cycle set-up for the state being entered
  // ---------------------------------------------------------------
  always_comb begin
    seq_reg   = REG_ZERO;
    bus_req   = 1'b1;
    bus_we    = 1'b0;
    bus_addr  = seq_addr;
    bus_wdata = 16'h0000;
    bus_code  = BST_WS;
    unique case (next_state)
      S_IDLE, S_EXT_WAIT: begin
        bus_req  = 1'b0;
        bus_addr = 16'h0000;
        bus_code = BST_GM;
      end
      S_RD_WP: begin
        bus_addr = next_vec;
        bus_code = (next_is_xop || next_vec != RESET_VEC) ? BST_INTA : BST_GM;
      end
      S_RD_PC: begin
        bus_addr = 16'(next_vec + VEC_PC_OFS);
        bus_code = BST_INTA;
      end
      S_WP_UPD: begin
        bus_addr = next_tmp_wp;
        bus_code = BST_WP_UPD;
      end
      S_ST_UPD: begin
        bus_addr = next_st & ST_UPD_MASK;
        bus_code = BST_STATUS;
      end
      S_WR13, S_RD13: begin
        seq_reg   = REG_SAVED_WP;
        bus_we    = (next_state == S_WR13);
        bus_wdata = next_old_wp;
      end
      S_WR14, S_RD14: begin
        seq_reg   = REG_SAVED_PC;
        bus_we    = (next_state == S_WR14);
        bus_wdata = next_old_pc;
      end
      S_WR15, S_RD15: begin
        seq_reg   = REG_SAVED_ST;
        bus_we    = (next_state == S_WR15);
        bus_wdata = next_old_st;
      end
      S_WR11: begin
        seq_reg   = REG_LINK;
        bus_we    = 1'b1;
        bus_wdata = next_ea;
      end
    endcase
  end

  // Operand register selection, by number or by dedicated role
  assign op_reg = reg_role_sel_i ? wsc_role_reg(reg_role_i) : reg_num_i;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;        mode <= M_TRAP;        base <= 16'h0000;
      vec <= 16'h0000;        tmp_wp <= 16'h0000;    tmp_pc <= 16'h0000;
      tmp_st <= 16'h0000;     old_wp <= 16'h0000;    old_pc <= 16'h0000;
      old_st <= 16'h0000;     ea <= 16'h0000;        is_xop <= 1'b0;
      ld_st <= 1'b0;          rst_pend <= 1'b1;
      wp_o <= 16'h0000;       pc_o <= 16'h0000;      st_o <= 16'h0000;
      ext_owner_o <= 1'b0;    macro_mode_o <= 1'b0;  busy_o <= 1'b1;
      mem_req_o <= 1'b0;      mem_we_o <= 1'b0;      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000; mem_code_o <= BST_RESET;
      reg_addr_o <= 16'h0000; reg_addr_vld_o <= 1'b0; idx_fault_o <= 1'b0;
      macro_code_o <= BST_GM; macro_region_o <= MREG_EXTERNAL;
    end else begin
      state <= next_state;    mode <= next_mode;     base <= next_base;
      vec <= next_vec;        tmp_wp <= next_tmp_wp; tmp_pc <= next_tmp_pc;
      tmp_st <= next_tmp_st;  old_wp <= next_old_wp; old_pc <= next_old_pc;
      old_st <= next_old_st;  ea <= next_ea;         is_xop <= next_is_xop;
      ld_st <= next_ld_st;    rst_pend <= next_rst_pend;
      wp_o <= next_wp & WORD_MASK;
      pc_o <= next_pc;        st_o <= next_st;
      ext_owner_o <= next_ext_owner;
      macro_mode_o <= next_macro_mode;
      busy_o <= (next_state != S_IDLE) || next_rst_pend;
      mem_req_o <= bus_req;   mem_we_o <= bus_we;    mem_addr_o <= bus_addr;
      mem_wdata_o <= bus_wdata; mem_code_o <= bus_code;
      reg_addr_o <= op_addr;
      reg_addr_vld_o <= reg_req_i && !(reg_idx_i && !op_idx_ok);
      idx_fault_o <= reg_req_i && reg_idx_i && !op_idx_ok;
      // Macro accesses differ from main memory only by code
      macro_code_o <= macro_acc_i ? BST_AUMS : BST_GM;
      macro_region_o <= m_region;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  wp_lsb_a: assert property (wp_o[0] == 1'b0)
    else $error("pointer bit zero not low");
  idx_zero_a: assert property (
    reg_req_i && reg_idx_i && op_reg == REG_ZERO |=> idx_fault_o && !reg_addr_vld_o)
    else $error("register zero accepted as index");
  mul_low_a: assert property (
    reg_req_i && reg_role_sel_i && reg_role_i == ROLE_MUL_LO
    |=> reg_addr_o == 16'($past(wp_o) + 16'h0002))
    else $error("low product word not register one");
  save_wp_a: assert property (
    state == S_WR13 && mem_req_o
    |-> mem_we_o && mem_addr_o == 16'(wp_o + 16'h001A) && mem_wdata_o == old_wp)
    else $error("saved pointer write misplaced");
  wp_cycle_a: assert property (
    state == S_WP_UPD |-> mem_code_o == BST_WP_UPD && mem_addr_o == tmp_wp)
    else $error("pointer update cycle wrong");
  st_cycle_a: assert property (
    state == S_ST_UPD |-> mem_code_o == BST_STATUS && mem_addr_o == (st_o & ST_UPD_MASK))
    else $error("status update cycle wrong");
  ret_reload_a: assert property (
    state == S_WP_UPD && mode == M_RET && mem_ack_i
    |=> state == S_ST_UPD && wp_o == $past(tmp_wp) && pc_o == $past(tmp_pc)
        && st_o == $past(tmp_st))
    else $error("return did not reload context");
  ext_hold_a: assert property (
    state == S_WR15 && mode == M_EXT && mem_ack_i
    |=> ext_owner_o && !mem_req_o [*2])
    else $error("handover did not release the bus");
  macro_trap_a: assert property (
    state == S_IDLE && !rst_pend && !trap_req_i && !ret_req_i && !ext_enter_i
    && macro_trap_i |=> pc_o == MACRO_TRAP_PC && macro_mode_o)
    else $error("macro trap not taken");
  trap_start_a: assert property (
    state == S_IDLE && !rst_pend && trap_req_i
    |=> state == S_RD_WP && mem_req_o && mem_addr_o == ($past(trap_vec_i) & WORD_MASK))
    else $error("trap did not fetch its vector");

endmodule : wsc_ctx_switch

// *** wsc_pkg.sv ***
/*
  Shared constants and types for the workspace context-switch block.
  Assumes one 16-bit local bus with a single-clock request/acknowledge handshake.
*/
package wsc_pkg;

  // ---------------------------------------------------------------
  // Widths and masks
  // ---------------------------------------------------------------
  localparam int          WS_REGS       = 16;
  localparam logic [15:0] WORD_MASK     = 16'hFFFE; // Bit zero forced low
  localparam logic [15:0] ST_UPD_MASK   = 16'h01F0; // Status bits 7-11, msb-first numbering
  localparam logic [15:0] VEC_PC_OFS    = 16'h0002;
  localparam logic [15:0] RESET_VEC     = 16'h0000;
  localparam logic [15:0] MACRO_TRAP_PC = 16'h0000; // Entry of macroinstruction emulation

  // ---------------------------------------------------------------
  // Macro space layout
  // ---------------------------------------------------------------
  localparam logic [15:0] MACRO_ONCHIP_END = 16'h1000; // 4K on-chip
  localparam logic [15:0] MACRO_ROM_END    = 16'h0400; // 1K ROM
  localparam logic [15:0] MACRO_RAM_BASE   = 16'h0800;
  localparam logic [15:0] MACRO_RAM_END    = 16'h0820; // 32 bytes RAM

  // ---------------------------------------------------------------
  // Dedicated register numbers
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_ZERO      = 4'h0;
  localparam logic [3:0] REG_ONE       = 4'h1;
  localparam logic [3:0] REG_LINK      = 4'hB;
  localparam logic [3:0] REG_BITIO     = 4'hC;
  localparam logic [3:0] REG_SAVED_WP  = 4'hD;
  localparam logic [3:0] REG_SAVED_PC  = 4'hE;
  localparam logic [3:0] REG_SAVED_ST  = 4'hF;

  // ---------------------------------------------------------------
  // Bus status codes, {mem, bst1, bst2, bst3}
  // ---------------------------------------------------------------
  localparam logic [3:0] BST_WS     = 4'h6;
  localparam logic [3:0] BST_INTA   = 4'h5;
  localparam logic [3:0] BST_GM     = 4'h7;
  localparam logic [3:0] BST_AUMS   = 4'h9;
  localparam logic [3:0] BST_RESET  = 4'hA;
  localparam logic [3:0] BST_WP_UPD = 4'hC;
  localparam logic [3:0] BST_STATUS = 4'hD;
  localparam logic [3:0] BST_MID    = 4'hE;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TRAP_VECTOR_CALL, TRAP_EXT_OP, TRAP_DEVICE_INT, TRAP_ARITH_FAULT,
    TRAP_PRIV, TRAP_ILLEGAL, TRAP_RESET, TRAP_NMI
  } wsc_trap_t;

  typedef enum logic [3:0] {
    ROLE_SHIFT_CNT, ROLE_MUL_HI, ROLE_MUL_LO, ROLE_DIV_HI, ROLE_DIV_LO,
    ROLE_LINK, ROLE_XOP_EA, ROLE_BITIO_BASE, ROLE_SAVED_WP, ROLE_SAVED_PC,
    ROLE_SAVED_ST
  } wsc_role_t;

  typedef enum logic [1:0] {
    MREG_ROM, MREG_RAM, MREG_RESERVED, MREG_EXTERNAL
  } wsc_mregion_t;

  // Register number that serves a dedicated role
  function automatic logic [3:0] wsc_role_reg(input wsc_role_t role);
    logic [3:0] r;
    r = REG_ZERO;
    unique case (role)
      ROLE_SHIFT_CNT, ROLE_MUL_HI, ROLE_DIV_HI: r = REG_ZERO;
      ROLE_MUL_LO, ROLE_DIV_LO:                 r = REG_ONE;
      ROLE_LINK, ROLE_XOP_EA:                   r = REG_LINK;
      ROLE_BITIO_BASE:                          r = REG_BITIO;
      ROLE_SAVED_WP:                            r = REG_SAVED_WP;
      ROLE_SAVED_PC:                            r = REG_SAVED_PC;
      default:                                  r = REG_SAVED_ST;
    endcase
    return r;
  endfunction : wsc_role_reg

endpackage : wsc_pkg

// *** wsc_ws_addr.sv ***
/*
  Workspace register address generator.
  Assumes a word-aligned base; purely combinational.
*/
module wsc_ws_addr (
  input  wire logic [15:0] base_i,
  input  wire logic [3:0]  reg_num_i,
  output logic      [15:0] addr_o,
  output logic             idx_ok_o
);
  import wsc_pkg::*;

  // ---------------------------------------------------------------
  // Address and index check
  // ---------------------------------------------------------------
  // Base plus twice the register number
  assign addr_o   = 16'(base_i + {11'h000, reg_num_i, 1'b0});
  // Register zero never indexes
  assign idx_ok_o = (reg_num_i != REG_ZERO);

endmodule : wsc_ws_addr

// *** wsc_macro_map.sv ***
/*
  Macro address space region decoder.
  Assumes a 16-bit byte address within the separate macro space.
*/
module wsc_macro_map (
  input  wire logic [15:0]          addr_i,
  output wsc_pkg::wsc_mregion_t     region_o
);
  import wsc_pkg::*;

  // ---------------------------------------------------------------
  // Region decode
  // ---------------------------------------------------------------
  // On-chip ROM and RAM in the low 4K, the rest external
  always_comb begin
    if (addr_i >= MACRO_ONCHIP_END)
      region_o = MREG_EXTERNAL;
    else if (addr_i < MACRO_ROM_END)
      region_o = MREG_ROM;
    else if (addr_i >= MACRO_RAM_BASE && addr_i < MACRO_RAM_END)
      region_o = MREG_RAM;
    else
      region_o = MREG_RESERVED;
  end

endmodule : wsc_macro_map

// *** wsc_mem_model.sv ***
/*
  Behavioural main memory on the local bus.
  Assumes a held request that is completed by a one-cycle acknowledge.
*/
module wsc_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        slow_i,
  input  wire logic        mem_req_o,
  input  wire logic        mem_we_o,
  input  wire logic [15:0] mem_addr_o,
  input  wire logic [15:0] mem_wdata_o,
  output logic             mem_ack_i,
  output logic [15:0]      mem_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:32767];
  int          dly = 0;
  initial begin
    mem_ack_i = 1'b0;
    mem_rdata_i = 16'h0000;
  end
  // -------------------------------------------------------------
  // Answer each held request, at once or after two stall cycles
  // -------------------------------------------------------------
  always @(posedge mclk_i) begin
    mem_ack_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i; // Released data never keeps its value
    if (mem_req_o && !mem_ack_i) begin
      if (dly < (slow_i ? 2 : 0)) begin
        dly = dly + 1;
      end else begin
        dly = 0;
        mem_ack_i <= 1'b1;
        if (mem_we_o) mem[mem_addr_o[15:1]] <= mem_wdata_o;
        else mem_rdata_i <= mem[mem_addr_o[15:1]];
      end
    end
  end
endmodule : wsc_mem_model

// *** tb.sv ***
/*
  Self-checking bench for the context-switch sequencer.
  Assumes the memory model stands alone on the local bus.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wsc_pkg::*;
  logic mclk_i = 0, rstn_i = 0, slow_i = 0, trap_req_i = 0, trap_ld_st_i = 0, ret_req_i = 0;
  logic ext_enter_i = 0, ext_return_i = 0, macro_trap_i = 0, reg_req_i = 0;
  logic reg_role_sel_i = 0, reg_idx_i = 0, macro_acc_i = 0;
  wsc_trap_t trap_kind_i = TRAP_VECTOR_CALL;
  wsc_role_t reg_role_i = ROLE_BITIO_BASE;
  logic [3:0] reg_num_i = 4'h0, mem_code_o, macro_code_o, n;
  logic [15:0] trap_vec_i = 0, trap_st_i = 0, trap_ea_i = 0, macro_addr_i = 0;
  logic mem_ack_i, mem_req_o, mem_we_o, reg_addr_vld_o, idx_fault_o, busy_o;
  logic ext_owner_o, macro_mode_o;
  logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, reg_addr_o, wp_o, pc_o, st_o;
  logic [15:0] ew, ep, es, ow, op, os, nw, np, v;
  wsc_mregion_t macro_region_o;
  int error_cnt = 0, tests_run = 0, seed = 32'hC8A8D3D0;
  wsc_ctx_switch u_dut (.*);
  wsc_mem_model u_mem (.*);
  always #25 mclk_i = ~mclk_i;
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] rd(input logic [15:0] a);
    return u_mem.mem[a[15:1]];
  endfunction : rd
  task automatic idle_wait;
    int k;
    k = 0;
    repeat (2) @(posedge mclk_i);
    #1;
    // Busy is looked at once it has settled after each edge
    while (busy_o !== 1'b0 && k < 300) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    if (k == 300) error_cnt++;
  endtask : idle_wait
  // Pulse one request for a cycle, then let the sequence finish
  task automatic go(input int k);
    @(posedge mclk_i);
    case (k)
      0: trap_req_i <= 1'b1;
      1: ret_req_i <= 1'b1;
      2: ext_enter_i <= 1'b1;
      default: ext_return_i <= 1'b1;
    endcase
    @(posedge mclk_i);
    {trap_req_i, ret_req_i, ext_enter_i, ext_return_i} <= 4'h0;
    if (k == 2) repeat (30) @(posedge mclk_i);
    else idle_wait;
  endtask : go
  task automatic end_of_test;
    $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    #250000;
    error_cnt++;
    end_of_test;
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    u_mem.mem[0] = 16'h0100;
    u_mem.mem[1] = 16'h0200;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    idle_wait;
    {ew, ep, es} = {16'h0100, 16'h0200, 16'h0000};
    chk(wp_o, ew);
    chk(pc_o, ep);
    $display("reset trap checked");
    for (int i = 0; i < 6; i++) begin
      nw = {2'b01, 9'($random(seed)), 5'h00};
      np = 16'($random(seed)) & WORD_MASK;
      v = 16'h0080 + 16'(i * 4);
      u_mem.mem[v[15:1]] = nw;
      u_mem.mem[v[15:1] + 1] = np;
      {ow, op, os} = {ew, ep, es};
      @(posedge mclk_i);
      trap_kind_i <= i[0] ? TRAP_EXT_OP : TRAP_VECTOR_CALL;
      trap_vec_i <= v;
      trap_ld_st_i <= i[0];
      trap_st_i <= 16'($random(seed));
      trap_ea_i <= 16'($random(seed));
      slow_i <= i[1];
      go(0);
      chk(wp_o, nw);
      chk(pc_o, np);
      chk(rd(nw + 16'h1A), ew);
      chk(rd(nw + 16'h1C), ep);
      chk(rd(nw + 16'h1E), es);
      if (i[0]) chk(rd(nw + 16'h16), trap_ea_i);
      if (i[0]) es = trap_st_i;
      chk(st_o, es);
      {ew, ep} = {nw, np};
      // Operand address, register zero refused as index
      @(posedge mclk_i);
      reg_req_i <= 1'b1;
      reg_num_i <= (i == 0) ? 4'h0 : 4'($random(seed));
      reg_idx_i <= !i[2];
      reg_role_sel_i <= i[2];
      reg_role_i <= (i == 5) ? ROLE_MUL_LO : ROLE_BITIO_BASE;
      @(posedge mclk_i);
      reg_req_i <= 1'b0;
      #1;
      n = i[2] ? ((i == 5) ? REG_ONE : REG_BITIO) : reg_num_i;
      chk({15'h0000, (n == 0 && !i[2]) ? idx_fault_o : reg_addr_vld_o}, 16'h0001);
      if (n != 0 || i[2]) chk(reg_addr_o, nw + {11'h000, n, 1'b0});
      if (i[0]) begin
        go(1);
        chk(wp_o, ow);
        chk(pc_o, op);
        chk(st_o, os);
        {ew, ep, es} = {ow, op, os};
      end
      $display("trap pass %0d checked", i);
    end
    go(2);
    chk({15'h0000, ext_owner_o}, 16'h0001);
    chk(rd(ew + 16'h1C), ep);
    u_mem.mem[ew[15:1] + 14] = 16'h1234;
    go(3);
    chk(pc_o, 16'h1234);
    chk(wp_o, ew);
    chk(st_o, es);
    chk({15'h0000, ext_owner_o}, 16'h0000);
    $display("handover checked");
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk_i);
      macro_acc_i <= (k < 4);
      macro_addr_i <= (k == 1) ? 16'h0810 : (k == 2) ? 16'h0C00 : (k == 3) ? 16'h2000 : 16'h0010;
      @(posedge mclk_i);
      #1;
      chk({12'h000, macro_code_o}, (k < 4) ? 16'h0009 : 16'h0007);
      if (k < 4) chk(16'(macro_region_o), 16'(k));
    end
    $display("macro space checked");
    // Macroinstruction trap from idle, then a return leaves macro mode
    @(posedge mclk_i);
    macro_trap_i <= 1'b1;
    @(posedge mclk_i);
    macro_trap_i <= 1'b0;
    #1;
    chk(pc_o, MACRO_TRAP_PC);
    chk({15'h0000, macro_mode_o}, 16'h0001);
    go(1);
    chk({15'h0000, macro_mode_o}, 16'h0000);
    chk(pc_o, 16'h1234);
    chk(wp_o, ew);
    $display("macro trap checked");
    end_of_test;
  end
endmodule : tb
